// ==== common/ecc_pkg.sv ====
// Shared constants, opcodes and types of the enhanced 8-bit execution core.
package ecc_pkg;
  // Status register bit positions; the extend-disable bit selects page stack mode.
  localparam int P_C = 0;
  localparam int P_Z = 1;
  localparam int P_I = 2;
  localparam int P_D = 3;
  localparam int P_E = 5;
  localparam int P_V = 6;
  localparam int P_N = 7;

  // Flag update masks handed back by the arithmetic unit.
  localparam logic [7:0] FM_NZ   = 8'h82;
  localparam logic [7:0] FM_NZC  = 8'h83;
  localparam logic [7:0] FM_NVZ  = 8'hc2;
  localparam logic [7:0] FM_NVZC = 8'hc3;

  // Reset values, address step constants and decimal adjust constants.
  localparam logic [7:0]  RESET_SP_PAGE = 8'h01;
  localparam logic [7:0]  RESET_SP_LOW  = 8'hff;
  localparam logic [7:0]  RESET_P       = 8'h24;
  localparam logic [15:0] RESET_VECTOR  = 16'hfffc;
  localparam logic [15:0] STEP_UP       = 16'h0001;
  localparam logic [15:0] STEP_DOWN     = 16'hffff;
  localparam logic [4:0]  BCD_MAX       = 5'h09;
  localparam logic [3:0]  BCD_FIX       = 4'h6;

  // Conditional word branches share one low pattern; bits 7:5 pick the test.
  localparam logic [4:0] BR_LOW = 5'h13;
  localparam logic [7:0]
    OP_BRU = 8'h83, OP_BSR = 8'h63, OP_JSRI = 8'h22, OP_JSRIX = 8'h23,
    OP_RTN = 8'h62, OP_RTS = 8'h60, OP_NEG = 8'h42, OP_ASRA = 8'h43,
    OP_ASRB = 8'h44, OP_ASRBX = 8'h54, OP_INW = 8'he3, OP_DEW = 8'hc3,
    OP_INZ = 8'h1b, OP_DEZ = 8'h3b, OP_ASW = 8'hcb, OP_ROW = 8'heb,
    OP_ORAZ = 8'h12, OP_ANDZ = 8'h32, OP_EORZ = 8'h52, OP_ADCZ = 8'h72,
    OP_CMPZ = 8'hd2, OP_SBCZ = 8'hf2, OP_CPZI = 8'hc2, OP_CPZB = 8'hd4,
    OP_CPZA = 8'hdc, OP_CLE = 8'h02, OP_SEE = 8'h03, OP_TAB = 8'h5b,
    OP_TAZ = 8'h4b, OP_TXS = 8'h9a, OP_TYS = 8'h2b, OP_LDAS = 8'he2,
    OP_STAS = 8'h82, OP_LDAI = 8'ha9, OP_LDXI = 8'ha2, OP_LDYI = 8'ha0,
    OP_LDZI = 8'ha3, OP_ADCI = 8'h69, OP_SBCI = 8'he9, OP_BITI = 8'h89,
    OP_LDAB = 8'ha5, OP_STAB = 8'h85, OP_STZB = 8'h64, OP_SED = 8'hf8,
    OP_CLD = 8'hd8, OP_CLC = 8'h18, OP_SEC = 8'h38;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ORA, ALU_AND, ALU_EOR, ALU_ADC, ALU_SBC,
    ALU_CMP, ALU_BIT, ALU_ASR, ALU_NEG, ALU_INC, ALU_DEC
  } ecc_aluop_t;

  typedef enum logic [1:0] {W_INC, W_DEC, W_ASL, W_ROL} ecc_wop_t;

  typedef enum logic [13:0] {
    S_VECL  = 14'h0001, S_VECH  = 14'h0002, S_FETCH = 14'h0004,
    S_OPA   = 14'h0008, S_OPB   = 14'h0010, S_PTRL  = 14'h0020,
    S_PTRH  = 14'h0040, S_RDL   = 14'h0080, S_RDH   = 14'h0100,
    S_WRH   = 14'h0200, S_WDONE = 14'h0400, S_PUSHL = 14'h0800,
    S_PULLL = 14'h1000, S_PULLH = 14'h2000
  } ecc_state_t;

  typedef struct packed {
    ecc_state_t  st;
    logic [7:0]  opc;
    logic [7:0]  a;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [7:0]  z;
    logic [7:0]  b;
    logic [7:0]  p;
    logic [7:0]  cnt;
    logic [7:0]  wdata;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] t;
    logic [15:0] ea;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
  } ecc_regs_t;
endpackage

// ==== common/ecc_alu_if.sv ====
// Carrier between the core sequencer and its arithmetic unit.
`timescale 1ns/10ps
interface ecc_alu_if import ecc_pkg::*; ();
  ecc_aluop_t  op;
  ecc_wop_t    wop;
  logic [7:0]  a;
  logic [7:0]  b;
  logic        cin;
  logic        dec;
  logic [15:0] w;
  logic [7:0]  res;
  logic [7:0]  flags;
  logic [7:0]  mask;
  logic [15:0] wres;
  logic [7:0]  wflags;
  logic [7:0]  wmask;

  modport core (output op, wop, a, b, cin, dec, w,
                input  res, flags, mask, wres, wflags, wmask);
  modport alu  (input  op, wop, a, b, cin, dec, w,
                output res, flags, mask, wres, wflags, wmask);
endinterface

// ==== design/ecc_alu.sv ====
// Combinational byte and word arithmetic unit of the execution core.
`timescale 1ns/10ps
module ecc_alu
  import ecc_pkg::*;
(
  ecc_alu_if.alu io
);
  // Nibble decimal correction; add corrects on carry, subtract on borrow.
  function automatic logic [3:0] adj(input logic [3:0] v, input logic c, input logic sub);
    if (sub) begin
      return c ? v : v - BCD_FIX;
    end
    return c ? v + BCD_FIX : v;
  endfunction

  // Byte path first, then the word path used by the read-modify-write words.
  always_comb begin
    logic [7:0]  bb;
    logic [8:0]  bin;
    logic [8:0]  cmp;
    logic [4:0]  lo;
    logic [4:0]  hi;
    logic        loC;
    logic        hiC;
    logic        sub;
    logic [7:0]  sum;
    logic        sumC;
    logic        v;
    logic        c;
    logic [16:0] wx;
    wx   = 17'h00000;
    sub  = io.op == ALU_SBC;
    bb   = sub ? ~io.b : io.b;
    bin  = {1'b0, io.a} + {1'b0, bb} + {8'h00, io.cin};
    cmp  = {1'b0, io.a} - {1'b0, io.b};
    lo   = {1'b0, io.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, io.cin};
    loC  = sub ? lo[4] : (lo > BCD_MAX);
    hi   = {1'b0, io.a[7:4]} + {1'b0, bb[7:4]} + {4'h0, loC};
    hiC  = sub ? hi[4] : (hi > BCD_MAX);
    sum  = bin[7:0];
    sumC = bin[8];
    // Decimal mode: flags follow the corrected result, not the binary one.
    if (io.dec) begin
      sum  = {adj(hi[3:0], hiC, sub), adj(lo[3:0], loC, sub)};
      sumC = hiC;
    end
    v       = (io.a[7] == bb[7]) && (sum[7] != io.a[7]);
    c       = sumC;
    io.res  = io.b;
    io.mask = FM_NZ;
    case (io.op)
      ALU_ORA: io.res = io.a | io.b;
      ALU_AND: io.res = io.a & io.b;
      ALU_EOR: io.res = io.a ^ io.b;
      ALU_ADC, ALU_SBC: begin
        io.res  = sum;
        io.mask = FM_NVZC;
      end
      ALU_CMP: begin
        io.res  = cmp[7:0];
        c       = !cmp[8];
        io.mask = FM_NZC;
      end
      ALU_BIT: begin
        io.res  = io.a & io.b;
        io.mask = FM_NVZ;
      end
      ALU_ASR: begin
        io.res  = {io.a[7], io.a[7:1]};
        c       = io.a[0];
        io.mask = FM_NZC;
      end
      ALU_NEG: io.res = 8'h00 - io.a;
      ALU_INC: io.res = io.a + 8'h01;
      ALU_DEC: io.res = io.a - 8'h01;
      default: io.res = io.b;
    endcase
    io.flags      = 8'h00;
    io.flags[P_N] = (io.op == ALU_BIT) ? io.b[7] : io.res[7];
    io.flags[P_V] = (io.op == ALU_BIT) ? io.b[6] : v;
    io.flags[P_Z] = io.res == 8'h00;
    io.flags[P_C] = c;
    // Word operations on a 16-bit memory operand.
    case (io.wop)
      W_INC:   wx = {1'b0, io.w + STEP_UP};
      W_DEC:   wx = {1'b0, io.w - STEP_UP};
      W_ASL:   wx = {io.w, 1'b0};
      default: wx = {io.w, io.cin};
    endcase
    io.wres        = wx[15:0];
    io.wmask       = (io.wop == W_INC || io.wop == W_DEC) ? FM_NZ : FM_NZC;
    io.wflags      = 8'h00;
    io.wflags[P_N] = wx[15];
    io.wflags[P_Z] = wx[15:0] == 16'h0000;
    io.wflags[P_C] = wx[16];
  end
endmodule

// ==== design/ecc_core.sv ====
// Execution core of the enhanced 8-bit processor with its memory port.
`timescale 1ns/10ps
module ecc_core
  import ecc_pkg::*;
#(
  parameter logic [15:0] RESET_VEC = RESET_VECTOR
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  memRdata,
  output logic [15:0]      memAddr,
  output logic             memRd,
  output logic             memWr,
  output logic [7:0]       memWdata,
  output logic             opFetch
);
  // The vector high byte is read from the next address, which must exist.
  if (RESET_VEC == STEP_DOWN) begin : g_vec_check
    $error("Reset vector must leave room for its high byte.");
  end

  localparam ecc_regs_t RST_VAL = '{
    st: S_VECL, opc: 8'h00, a: 8'h00, x: 8'h00, y: 8'h00,
    z: 8'h00,
    b: 8'h00,
    p: RESET_P, cnt: 8'h00, wdata: 8'h00, pc: 16'h0000,
    sp: {RESET_SP_PAGE, RESET_SP_LOW},
    t: 16'h0000, ea: 16'h0000, addr: RESET_VEC, rd: 1'b1, wr: 1'b0
  };

  ecc_regs_t  r_reg;
  ecc_regs_t  r_next;
  ecc_alu_if  alu ();

  ecc_alu u_alu (
    .io (alu.alu)
  );

  // Stack step: page mode only moves the low byte so the page never changes.
  function automatic logic [15:0] spStep(input logic [15:0] sp, input logic [15:0] d,
                                         input logic pageMode);
    if (pageMode) begin
      return {sp[15:8], sp[7:0] + d[7:0]};
    end
    return sp + d;
  endfunction

  // Base-page address: relocated page with an in-page offset.
  function automatic logic [15:0] bpAddr(input logic [7:0] page, input logic [7:0] off);
    return {page, off};
  endfunction

  // Second byte of a pair; base-page pairs wrap inside their page.
  function automatic logic [15:0] nextAddr(input logic [15:0] ea, input logic wrap);
    return wrap ? {ea[15:8], ea[7:0] + 8'h01} : ea + STEP_UP;
  endfunction

  function automatic logic [7:0] mergeFlags(input logic [7:0] p, input logic [7:0] f,
                                            input logic [7:0] m);
    return (p & ~m) | (f & m);
  endfunction

  function automatic logic bpWrap(input logic [7:0] o);
    return o inside {OP_ORAZ, OP_ANDZ, OP_EORZ, OP_ADCZ, OP_CMPZ, OP_SBCZ, OP_INW,
                     OP_DEW};
  endfunction

  function automatic logic isBranch(input logic [7:0] o);
    return o[4:0] == BR_LOW;
  endfunction

  // Opcodes that carry at least one operand byte; anything unknown is a one-byte no-op.
  function automatic logic isMulti(input logic [7:0] o);
    return isBranch(o) || o inside {OP_RTN, OP_LDAI, OP_LDXI, OP_LDYI, OP_LDZI,
      OP_ADCI, OP_SBCI, OP_BITI, OP_CPZI, OP_LDAB, OP_STAB, OP_STZB, OP_ASRB,
      OP_ASRBX, OP_CPZB, OP_INW, OP_DEW, OP_ORAZ, OP_ANDZ, OP_EORZ, OP_ADCZ,
      OP_CMPZ, OP_SBCZ, OP_LDAS, OP_STAS, OP_BRU, OP_BSR, OP_JSRI, OP_JSRIX,
      OP_ASW, OP_ROW, OP_CPZA};
  endfunction

  // Condition bits 2:1 pick N, V, C or Z; bit 0 asks for the flag set.
  function automatic logic condMet(input logic [2:0] sel, input logic [7:0] p);
    logic f;
    case (sel[2:1])
      2'h0:    f = p[P_N];
      2'h1:    f = p[P_V];
      2'h2:    f = p[P_C];
      default: f = p[P_Z];
    endcase
    return f == sel[0];
  endfunction

  function automatic ecc_aluop_t aluSel(input logic [7:0] o);
    case (o)
      OP_ORAZ:                     return ALU_ORA;
      OP_ANDZ:                     return ALU_AND;
      OP_EORZ:                     return ALU_EOR;
      OP_ADCI, OP_ADCZ:            return ALU_ADC;
      OP_SBCI, OP_SBCZ:            return ALU_SBC;
      OP_CMPZ, OP_CPZI, OP_CPZB,
      OP_CPZA:                     return ALU_CMP;
      OP_BITI:                     return ALU_BIT;
      OP_ASRA, OP_ASRB, OP_ASRBX:  return ALU_ASR;
      OP_NEG:                      return ALU_NEG;
      OP_INZ:                      return ALU_INC;
      OP_DEZ:                      return ALU_DEC;
      default:                     return ALU_PASS;
    endcase
  endfunction

  // Next-state logic: one memory access is issued per cycle and its read
  // data is consumed by the following state, so no cycle is ever spent on
  // a page crossing: sums are 16-bit except base-page and page-mode stack steps, which wrap in their page.
  always_comb begin
    logic [7:0]  cur;
    logic [15:0] word;
    logic        pm;
    cur  = (r_reg.st == S_FETCH) ? memRdata : r_reg.opc;
    word = {memRdata, r_reg.t[7:0]};
    pm   = r_reg.p[P_E];
    alu.op  = aluSel(cur);
    alu.a   = r_reg.a;
    if (cur inside {OP_INZ, OP_DEZ, OP_CPZI, OP_CPZB, OP_CPZA}) begin
      alu.a = r_reg.z;
    end else if (cur inside {OP_ASRB, OP_ASRBX}) begin
      alu.a = memRdata;
    end
    alu.b   = memRdata;
    alu.cin = r_reg.p[P_C];
    alu.dec = r_reg.p[P_D];
    case (r_reg.opc)
      OP_INW:  alu.wop = W_INC;
      OP_DEW:  alu.wop = W_DEC;
      OP_ASW:  alu.wop = W_ASL;
      default: alu.wop = W_ROL;
    endcase
    alu.w = word;
    r_next    = r_reg;
    r_next.rd = 1'b0;
    r_next.wr = 1'b0;
    case (r_reg.st)
      S_VECL: begin
        r_next.t[7:0] = memRdata;
        r_next.addr   = r_reg.addr + STEP_UP;
        r_next.rd     = 1'b1;
        r_next.st     = S_VECH;
      end
      S_VECH: begin
        r_next.pc   = word;
        r_next.addr = word;
        r_next.rd   = 1'b1;
        r_next.st   = S_FETCH;
      end
      S_FETCH: begin
        r_next.opc  = memRdata;
        r_next.cnt  = 8'h00;
        r_next.pc   = r_reg.pc + STEP_UP;
        r_next.addr = r_reg.pc + STEP_UP;
        r_next.rd   = 1'b1;
        r_next.st   = isMulti(memRdata) ? S_OPA : S_FETCH;
        case (memRdata)
          OP_NEG, OP_ASRA: begin
            r_next.a = alu.res;
            r_next.p = mergeFlags(r_reg.p, alu.flags, alu.mask);
          end
          OP_INZ, OP_DEZ: begin
            r_next.z = alu.res;
            r_next.p = mergeFlags(r_reg.p, alu.flags, alu.mask);
          end
          OP_CLE: r_next.p[P_E] = 1'b0;
          OP_SEE: r_next.p[P_E] = 1'b1;
          OP_SED: r_next.p[P_D] = 1'b1;
          OP_CLD: r_next.p[P_D] = 1'b0;
          OP_SEC: r_next.p[P_C] = 1'b1;
          OP_CLC: r_next.p[P_C] = 1'b0;
          OP_TAB: r_next.b = r_reg.a;
          OP_TAZ: r_next.z = r_reg.a;
          OP_TXS: r_next.sp[7:0] = r_reg.x;
          OP_TYS: r_next.sp[15:8] = r_reg.y;
          OP_RTS: begin
            r_next.sp   = spStep(r_reg.sp, STEP_UP, pm);
            r_next.addr = r_next.sp;
            r_next.st   = S_PULLL;
          end
          default: ;
        endcase
      end
      S_OPA: begin
        r_next.t[7:0] = memRdata;
        r_next.pc     = r_reg.pc + STEP_UP;
        r_next.addr   = r_reg.pc + STEP_UP;
        r_next.rd     = 1'b1;
        r_next.st     = S_OPB;
        case (r_reg.opc)
          OP_LDAI, OP_ADCI, OP_SBCI: begin
            r_next.a  = alu.res;
            r_next.p  = mergeFlags(r_reg.p, alu.flags, alu.mask);
            r_next.st = S_FETCH;
          end
          OP_LDXI, OP_LDYI, OP_LDZI, OP_BITI, OP_CPZI: begin
            r_next.x  = (r_reg.opc == OP_LDXI) ? alu.res : r_reg.x;
            r_next.y  = (r_reg.opc == OP_LDYI) ? alu.res : r_reg.y;
            r_next.z  = (r_reg.opc == OP_LDZI) ? alu.res : r_reg.z;
            r_next.p  = mergeFlags(r_reg.p, alu.flags, alu.mask);
            r_next.st = S_FETCH;
          end
          OP_RTN: begin
            r_next.cnt  = memRdata;
            r_next.sp   = spStep(r_reg.sp, STEP_UP, pm);
            r_next.addr = r_next.sp;
            r_next.st   = S_PULLL;
          end
          OP_STAB, OP_STZB: begin
            r_next.addr  = bpAddr(r_reg.b, memRdata);
            r_next.rd    = 1'b0;
            r_next.wr    = 1'b1;
            r_next.wdata = (r_reg.opc == OP_STAB) ? r_reg.a : r_reg.z;
            r_next.st    = S_WDONE;
          end
          OP_LDAB, OP_ASRB, OP_CPZB, OP_INW, OP_DEW, OP_ASRBX: begin
            r_next.ea   = bpAddr(r_reg.b, (r_reg.opc == OP_ASRBX) ? memRdata + r_reg.x
                                                                  : memRdata);
            r_next.addr = r_next.ea;
            r_next.st   = S_RDL;
          end
          OP_ORAZ, OP_ANDZ, OP_EORZ, OP_ADCZ, OP_CMPZ, OP_SBCZ: begin
            r_next.ea   = bpAddr(r_reg.b, memRdata);
            r_next.addr = r_next.ea;
            r_next.st   = S_PTRL;
          end
          OP_LDAS, OP_STAS: begin
            r_next.ea   = r_reg.sp + {8'h00, memRdata};
            r_next.addr = r_next.ea;
            r_next.st   = S_PTRL;
          end
          default: ;
        endcase
      end
      S_OPB: begin
        r_next.t[15:8] = memRdata;
        r_next.pc      = r_reg.pc + STEP_UP;
        r_next.addr    = r_reg.pc + STEP_UP;
        r_next.rd      = 1'b1;
        r_next.st      = S_FETCH;
        // Target is the next instruction plus a signed word, wrapping at 64 K.
        if (r_reg.opc == OP_BRU || (isBranch(r_reg.opc) && condMet(r_reg.opc[7:5], r_reg.p))) begin
          r_next.pc   = r_reg.pc + STEP_UP + word;
          r_next.addr = r_next.pc;
        end
        case (r_reg.opc)
          OP_BSR: begin
            r_next.pc    = r_reg.pc + STEP_UP + word;
            r_next.ea    = r_reg.pc;
            r_next.addr  = r_reg.sp;
            r_next.rd    = 1'b0;
            r_next.wr    = 1'b1;
            r_next.wdata = r_reg.pc[15:8];
            r_next.sp    = spStep(r_reg.sp, STEP_DOWN, pm);
            r_next.st    = S_PUSHL;
          end
          OP_JSRI, OP_JSRIX: begin
            r_next.ea   = word + ((r_reg.opc == OP_JSRIX) ? {8'h00, r_reg.x} : 16'h0000);
            r_next.addr = r_next.ea;
            r_next.st   = S_PTRL;
          end
          OP_ASW, OP_ROW, OP_CPZA: begin
            r_next.ea   = word;
            r_next.addr = word;
            r_next.st   = S_RDL;
          end
          default: ;
        endcase
      end
      S_PTRL: begin
        r_next.t[7:0] = memRdata;
        r_next.addr   = nextAddr(r_reg.ea, bpWrap(r_reg.opc));
        r_next.rd     = 1'b1;
        r_next.st     = S_PTRH;
      end
      S_PTRH: begin
        r_next.rd   = 1'b1;
        r_next.st   = S_RDL;
        r_next.ea   = word + {8'h00, r_reg.z};
        if (r_reg.opc inside {OP_LDAS, OP_STAS}) begin
          r_next.ea = word + {8'h00, r_reg.y};
        end
        r_next.addr = r_next.ea;
        if (r_reg.opc == OP_STAS) begin
          r_next.rd    = 1'b0;
          r_next.wr    = 1'b1;
          r_next.wdata = r_reg.a;
          r_next.st    = S_WDONE;
        end else if (r_reg.opc inside {OP_JSRI, OP_JSRIX}) begin
          r_next.pc    = word;
          r_next.ea    = r_reg.pc - STEP_UP;
          r_next.addr  = r_reg.sp;
          r_next.rd    = 1'b0;
          r_next.wr    = 1'b1;
          r_next.wdata = r_next.ea[15:8];
          r_next.sp    = spStep(r_reg.sp, STEP_DOWN, pm);
          r_next.st    = S_PUSHL;
        end
      end
      S_RDL: begin
        r_next.addr = r_reg.pc;
        r_next.rd   = 1'b1;
        r_next.st   = S_FETCH;
        case (r_reg.opc)
          OP_CPZB, OP_CPZA, OP_CMPZ: r_next.p = mergeFlags(r_reg.p, alu.flags, alu.mask);
          OP_ASRB, OP_ASRBX: begin
            r_next.p     = mergeFlags(r_reg.p, alu.flags, alu.mask);
            r_next.addr  = r_reg.ea;
            r_next.rd    = 1'b0;
            r_next.wr    = 1'b1;
            r_next.wdata = alu.res;
            r_next.st    = S_WDONE;
          end
          OP_INW, OP_DEW, OP_ASW, OP_ROW: begin
            r_next.t[7:0] = memRdata;
            r_next.addr   = nextAddr(r_reg.ea, bpWrap(r_reg.opc));
            r_next.st     = S_RDH;
          end
          default: begin
            r_next.a = alu.res;
            r_next.p = mergeFlags(r_reg.p, alu.flags, alu.mask);
          end
        endcase
      end
      S_RDH: begin
        r_next.t     = alu.wres;
        r_next.p     = mergeFlags(r_reg.p, alu.wflags, alu.wmask);
        r_next.addr  = r_reg.ea;
        r_next.wr    = 1'b1;
        r_next.wdata = alu.wres[7:0];
        r_next.st    = S_WRH;
      end
      S_WRH: begin
        r_next.addr  = nextAddr(r_reg.ea, bpWrap(r_reg.opc));
        r_next.wr    = 1'b1;
        r_next.wdata = r_reg.t[15:8];
        r_next.st    = S_WDONE;
      end
      S_PUSHL: begin
        r_next.addr  = r_reg.sp;
        r_next.wr    = 1'b1;
        r_next.wdata = r_reg.ea[7:0];
        r_next.sp    = spStep(r_reg.sp, STEP_DOWN, pm);
        r_next.st    = S_WDONE;
      end
      S_PULLL: begin
        r_next.t[7:0] = memRdata;
        r_next.sp     = spStep(r_reg.sp, STEP_UP, pm);
        r_next.addr   = r_next.sp;
        r_next.rd     = 1'b1;
        r_next.st     = S_PULLH;
      end
      S_PULLH: begin
        r_next.pc   = word + STEP_UP;
        r_next.addr = r_next.pc;
        r_next.rd   = 1'b1;
        r_next.sp   = spStep(r_reg.sp, {8'h00, r_reg.cnt}, pm);
        r_next.st   = S_FETCH;
      end
      default: begin
        r_next.addr = r_reg.pc;
        r_next.rd   = 1'b1;
        r_next.st   = S_FETCH;
      end
    endcase
  end

  // State register; reset restarts from the vector read.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_reg <= RST_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  // Memory port straight from the state register.
  assign memAddr  = r_reg.addr;
  assign memRd    = r_reg.rd;
  assign memWr    = r_reg.wr;
  assign memWdata = r_reg.wdata;
  assign opFetch  = r_reg.st == S_FETCH;
endmodule

// ==== test/ecc_mem_model.sv ====
// Behavioural memory answering the core in the same cycle.
`timescale 1ns/10ps
module ecc_mem_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRd,
  input  wire logic        memWr,
  input  wire logic [7:0]  memWdata,
  output logic [7:0]       memRdata
);
  logic [7:0] mem [65536];
  // Outside a read the byte is inverted so a stale value never passes as data.
  assign memRdata = memRd ? mem[memAddr] : ~mem[memAddr];
  // A write lands at the edge that ends its cycle; a plain always, since the bench preloads the array.
  always @(posedge core_clk) begin
    if (memWr) begin
      mem[memAddr] <= memWdata;
    end
  end
endmodule

// ==== test/ecc_core_assertions.sv ====
// Port-level checks of the execution core.
`timescale 1ns/10ps
module ecc_core_assertions
  import ecc_pkg::*;
#(
  parameter logic [15:0] RESET_VEC = RESET_VECTOR
)
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  memRdata,
  input wire logic [15:0] memAddr,
  input wire logic        memRd,
  input wire logic        memWr,
  input wire logic [7:0]  memWdata,
  input wire logic        opFetch
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_access; memRd ^ memWr; endproperty
  a_access: assert property (p_access) else $error("not one access");
  property p_boot; $fell(rst) |-> memAddr == RESET_VEC ##1 memAddr == RESET_VEC + 16'h1
    ##1 opFetch; endproperty
  a_boot: assert property (p_boot) else $error("bad start");
  property p_bru; opFetch && memRdata == OP_BRU |-> ##3 opFetch
    && memAddr == $past(memAddr, 3) + 16'h3 + {$past(memRdata), $past(memRdata, 2)}; endproperty
  a_bru: assert property (p_bru) else $error("bad branch");
  property p_bsr; opFetch && memRdata == OP_BSR |-> ##3 memWr
    && memWdata == 8'(($past(memAddr, 3) + 16'h2) >> 8) ##1 memWr
    && memAddr == $past(memAddr) - 16'h1 && memWdata == 8'($past(memAddr, 4) + 16'h2);
  endproperty
  a_bsr: assert property (p_bsr) else $error("bad call push");
  property p_inw; opFetch && memRdata == OP_INW |-> ##4 memWr && memAddr == $past(memAddr, 2)
    && memWdata == $past(memRdata, 2) + 8'h1 ##1 memWr && memAddr == $past(memAddr, 2)
    && memWdata == $past(memRdata, 2) + 8'($past(memRdata, 3) == 8'hff); endproperty
  a_inw: assert property (p_inw) else $error("bad word inc");
  property p_dew; opFetch && memRdata == OP_DEW |-> ##4 memWr
    && memWdata == $past(memRdata, 2) - 8'h1 ##1 memWr
    && memWdata == $past(memRdata, 2) - 8'($past(memRdata, 3) == 8'h00); endproperty
  a_dew: assert property (p_dew) else $error("bad word dec");
  property p_asr; opFetch && memRdata == OP_ASRB |-> ##3 memWr && memAddr == $past(memAddr)
    && memWdata == 8'($signed($past(memRdata)) >>> 1); endproperty
  a_asr: assert property (p_asr) else $error("bad shift");
  property p_inz; opFetch && memRdata == OP_INZ |=> opFetch
    && memAddr == $past(memAddr) + 16'h1; endproperty
  a_inz: assert property (p_inz) else $error("slow index step");
endmodule
bind ecc_core ecc_core_assertions #(.RESET_VEC(RESET_VEC)) u_chk (.core_clk, .rst,
  .memRdata, .memAddr, .memRd, .memWr, .memWdata, .opFetch);

// ==== test/ecc_core_tb_top.sv ====
// Self-checking bench running a short program on the core.
`timescale 1ns/10ps
module ecc_core_tb_top;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] memAddr;
  logic        memRd, memWr, opFetch;
  logic [7:0]  memRdata, memWdata, r1, r2, r3;
  logic [7:0]  prog [$];
  int          nErrors = 0;
  int          testsRun = 0;
  int          k;
  always #5 core_clk = ~core_clk;
  ecc_core i_dut (.core_clk, .rst, .memRdata, .memAddr, .memRd, .memWr, .memWdata, .opFetch);
  ecc_mem_model i_mem (.core_clk, .memAddr, .memRd, .memWr, .memWdata, .memRdata);
  function automatic logic [7:0] asr8(input logic [7:0] v);
    return {v[7], v[7:1]};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Word operands sit at carry and borrow corners; a long branch skips to the call at 0300.
  // The decimal subroutine at 0308 returns with two stack bytes released, wrapping in page 01.
  initial begin
    void'($urandom(32'h5a3d));
    r1 = 8'($urandom());
    r2 = 8'($urandom());
    r3 = 8'($urandom());
    prog = '{8'ha9, r1, 8'h42, 8'h85, 8'h10, 8'h64, 8'h11, 8'ha9, r2, 8'h85, 8'h12, 8'h44,
      8'h12, 8'he3, 8'h20, 8'hc3, 8'h22, 8'h1b, 8'h1b, 8'h3b, 8'h64, 8'h13, 8'h83, 8'he7, 8'h00,
      8'h63, 8'h05, 8'h00, 8'h82, 8'h01, 8'h5b, 8'h85, 8'h41, 8'hf8, 8'h18, 8'ha9, 8'h58,
      8'h69, 8'h46, 8'hd8, 8'h62, 8'h02};
    foreach (prog[i]) i_mem.mem[(i < 25) ? 16'h0200 + i : 16'h02e7 + i] = prog[i];
    i_mem.mem[16'hfffc] = 8'h00;
    i_mem.mem[16'hfffd] = 8'h02;
    i_mem.mem[16'h0020] = 8'hff;
    i_mem.mem[16'h0021] = r3;
    i_mem.mem[16'h0022] = 8'h00;
    i_mem.mem[16'h0023] = r3;
    i_mem.mem[16'h0102] = 8'h40;
    i_mem.mem[16'h0103] = 8'h00;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    for (k = 0; k < 300 && !(memWr === 1'b1 && memAddr === 16'h0441); k++) @(negedge core_clk);
    @(negedge core_clk);
    if (k == 300) begin
      nErrors++;
    end else begin
      chk("negate", i_mem.mem[16'h0010], 8'h00 - r1);
      chk("store zero", i_mem.mem[16'h0011], 8'h00);
      chk("shift", i_mem.mem[16'h0012], asr8(r2));
      chk("inc low", i_mem.mem[16'h0020], 8'h00);
      chk("inc high", i_mem.mem[16'h0021], r3 + 8'h1);
      chk("dec low", i_mem.mem[16'h0022], 8'hff);
      chk("dec high", i_mem.mem[16'h0023], r3 - 8'h1);
      chk("third index", i_mem.mem[16'h0013], 8'h01);
      chk("push high", i_mem.mem[16'h01ff], 8'h03);
      chk("push low", i_mem.mem[16'h01fe], 8'h02);
      // Decimal 58 plus 46 is 104, so the stored byte is 04 with carry out.
      chk("stack argument", i_mem.mem[16'h0040], 8'h04);
      chk("released stack", i_mem.mem[16'h0040], 8'h04);
      chk("decimal add", i_mem.mem[16'h0441], 8'h04);
      chk("relocated page", i_mem.mem[16'h0441], 8'h04);
    end
    wrap_up();
  end
endmodule
